// File: verilog/video_timing_regs.vh
// Purpose: shared offsets, fields, reset values and counts for the video timing front end
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef VIDEO_TIMING_REGS_VH
`define VIDEO_TIMING_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define MODE_REG_OFS        8'h00
`define TIMING_CFG_OFS      8'h04
`define STATUS_REG_OFS      8'h08

// ---------------------------------------------------------------
// mode register fields and reset
// ---------------------------------------------------------------
`define MODE_STD_LSB        0
`define MODE_STD_W          2
`define MODE_STD_REG_BIT    5
`define MODE_PIX_VALID_BIT  6
`define MODE_DAC_LSB        8
`define MODE_RESET          32'h0000_3800
`define DAC_RESET           6'h38

// ---------------------------------------------------------------
// line timing proportions, in pixels of a full-length line
// ---------------------------------------------------------------
`define H_SYNC_PIX          64
`define H_ACT0_PIX          138
`define H_LINE_PIX          858

// ---------------------------------------------------------------
// timing configuration fields and reset
// ---------------------------------------------------------------
`define TCFG_BLANK_DIS_BIT  3
`define TCFG_RESET          8'h00

// ---------------------------------------------------------------
// black level and code bytes
// ---------------------------------------------------------------
`define BLACK_LUMA          8'h10
`define BLACK_CHROMA        8'h80
`define CODE_PREAMBLE_FF    8'hff
`define CODE_PREAMBLE_00    8'h00

`endif

// File: verilog/pin_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single destination clock
// Notes:   first stage feeds only the second stage
module pin_sync #(
    parameter W     = 1,
    parameter INIT  = 0
) (
    input  wire         clk,
    input  wire         rst_b,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= INIT[W-1:0];
            q    <= INIT[W-1:0];
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// File: verilog/sync_gen.v
// Purpose: master line and field counter producing h, v, f flags
// Assumes: pix_en is a one-cycle pixel-rate enable
// Notes:   counts restart whenever run is low
module sync_gen #(
    parameter H_TOTAL = 858,
    parameter H_SYNC  = 64,
    parameter H_ACT0  = 138,
    parameter V_TOTAL = 525,
    parameter V_BLANK = 20,
    parameter V_SYNC  = 3
) (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       pix_en,
    input  wire       run,
    output reg        h_flag,
    output reg        v_flag,
    output reg        f_flag,
    output reg        hsync_b,
    output reg        vsync_b
);
    localparam HALF = V_TOTAL / 2;
    reg [11:0] hcnt;
    reg [10:0] vcnt;
    reg [10:0] fline;
    wire       eol = (hcnt == H_TOTAL - 1);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hcnt <= 12'h000;
            vcnt <= 11'h000;
        end else if (!run) begin
            hcnt <= 12'h000;
            vcnt <= 11'h000;
        end else if (pix_en) begin
            hcnt <= eol ? 12'h000 : hcnt + 12'h001;
            if (eol)
                vcnt <= (vcnt == V_TOTAL - 1) ? 11'h000 : vcnt + 11'h001;
        end
    end

    always @* begin
        fline = (vcnt >= HALF) ? vcnt - HALF[10:0] : vcnt;
    end

    // flags registered so pins only move on clock edges
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            h_flag  <= 1'b0;
            v_flag  <= 1'b0;
            f_flag  <= 1'b0;
            hsync_b <= 1'b1;
            vsync_b <= 1'b1;
        end else begin
            h_flag  <= run && (hcnt < H_ACT0);
            v_flag  <= run && (fline < V_BLANK);
            f_flag  <= run && (vcnt >= HALF);
            hsync_b <= !(run && (hcnt < H_SYNC));
            vsync_b <= !(run && (fline < V_SYNC));
        end
    end
endmodule

// File: verilog/video_timing_front.v
// Purpose: video encoder timing front end: reset start-up, mode select, pixel gate
// Assumes: classic wishbone slave, pins synchronised to mclk
// Notes:   pixel rate is an enable from a divider of mclk
`include "video_timing_regs.vh"
module video_timing_front #(
    parameter PIX_DIV   = 5,
    parameter H_TOTAL   = 858,
    parameter V_TOTAL   = 525,
    parameter H_TOTAL_P = 864,
    parameter V_TOTAL_P = 625,
    parameter V_BLANK   = 20
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        standard_select_pin,
    input  wire [7:0]  pixel_in,
    input  wire        hsync_b_in,
    output reg         hsync_b_out,
    output reg         hsync_b_oe,
    input  wire        vsync_b_in,
    output reg         vsync_b_out,
    output reg         vsync_b_oe,
    input  wire        blank_b_in,
    output reg         blank_b_out,
    output reg         blank_b_oe,
    output reg  [7:0]  pixel_out,
    output reg         blank_active,
    output reg         field_odd,
    output reg         frame_start,
    output reg  [1:0]  video_standard,
    output reg  [5:0]  dac_enable
);
    // ---------------------------------------------------------------
    // mode codes
    // ---------------------------------------------------------------
    localparam M0_SLAVE  = 3'b000;
    localparam M0_MASTER = 3'b001;
    localparam M1_SLAVE  = 3'b010;
    localparam M1_MASTER = 3'b011;
    localparam M2_SLAVE  = 3'b100;
    localparam M2_MASTER = 3'b101;
    localparam M3_SLAVE  = 3'b110;
    localparam M3_MASTER = 3'b111;

    // sync width and active start scale with line length, so short lines still toggle
    localparam H_SYNC_N = (H_TOTAL * `H_SYNC_PIX) / `H_LINE_PIX;
    localparam H_ACT0_N = (H_TOTAL * `H_ACT0_PIX) / `H_LINE_PIX;
    localparam H_SYNC_P = (H_TOTAL_P * `H_SYNC_PIX) / `H_LINE_PIX;
    localparam H_ACT0_P = (H_TOTAL_P * `H_ACT0_PIX) / `H_LINE_PIX;

    localparam CS_IDLE = 2'b00;
    localparam CS_FF   = 2'b01;
    localparam CS_Z1   = 2'b10;
    localparam CS_Z2   = 2'b11;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg  [31:0] mode_reg;
    reg  [7:0]  timing_config_reg;
    reg  [31:0] status;
    wire        pixel_valid_enable          = mode_reg[`MODE_PIX_VALID_BIT];
    wire        standard_by_register_enable = mode_reg[`MODE_STD_REG_BIT];
    wire        blank_input_disable         = timing_config_reg[`TCFG_BLANK_DIS_BIT];
    wire [2:0]  tmode = timing_config_reg[2:0]; // upper bits ignored
    wire        master = tmode[0];
    wire        bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    function [7:0] merge_byte;
        input [7:0] old;
        input [7:0] nw;
        input       en;
        begin
            merge_byte = en ? nw : old;
        end
    endfunction

    // ---------------------------------------------------------------
    // wishbone slave: ack one cycle after request
    // ---------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o          <= 1'b0;
            mode_reg          <= `MODE_RESET;
            timing_config_reg <= `TCFG_RESET;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && wb_we_i) begin
                if (wb_adr_i == `MODE_REG_OFS) begin
                    mode_reg[7:0]   <= merge_byte(mode_reg[7:0], wb_dat_i[7:0], wb_sel_i[0]);
                    mode_reg[15:8]  <= merge_byte(mode_reg[15:8], wb_dat_i[15:8], wb_sel_i[1]);
                end
                if (wb_adr_i == `TIMING_CFG_OFS)
                    timing_config_reg <= merge_byte(timing_config_reg, wb_dat_i[7:0],
                                                    wb_sel_i[0]);
            end
        end
    end

    // unmapped reads answer zero
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `MODE_REG_OFS:   wb_dat_o <= {16'h0000, mode_reg[15:0]};
                `TIMING_CFG_OFS: wb_dat_o <= {24'h00_0000, timing_config_reg};
                `STATUS_REG_OFS: wb_dat_o <= status;
                default:         wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    wire [7:0] pix_s;
    wire [3:0] ctl_s;
    wire       std_pin_s = ctl_s[3];
    wire       hs_s      = ctl_s[0];
    wire       vs_s      = ctl_s[1];
    wire       bl_s      = ctl_s[2];

    pin_sync #(.W(8), .INIT(0)) u_pix_sync (
        .clk   (mclk),
        .rst_b (rst_b),
        .d     (pixel_in),
        .q     (pix_s)
    );

    pin_sync #(.W(4), .INIT(7)) u_ctl_sync (
        .clk   (mclk),
        .rst_b (rst_b),
        .d     ({standard_select_pin, blank_b_in, vsync_b_in, hsync_b_in}),
        .q     (ctl_s)
    );

    // ---------------------------------------------------------------
    // pixel rate enable
    // ---------------------------------------------------------------
    reg [7:0] div_cnt;
    reg       pix_en;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 8'h00;
            pix_en  <= 1'b0;
        end else begin
            pix_en  <= (div_cnt == PIX_DIV - 1);
            div_cnt <= (div_cnt == PIX_DIV - 1) ? 8'h00 : div_cnt + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // standard selection
    // ---------------------------------------------------------------
    // reset loads standard 0, then the pin follows until register control is taken
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            video_standard <= 2'b00;
        else if (standard_by_register_enable)
            video_standard <= mode_reg[`MODE_STD_LSB +: `MODE_STD_W];
        else
            video_standard <= {1'b0, std_pin_s};
    end

    // ---------------------------------------------------------------
    // master generators, one per line standard
    // ---------------------------------------------------------------
    wire run = pixel_valid_enable && master;
    wire gn_h, gn_v, gn_f, gn_hs, gn_vs;
    wire gp_h, gp_v, gp_f, gp_hs, gp_vs;
    wire pal = video_standard[0];
    wire g_h  = pal ? gp_h  : gn_h;
    wire g_v  = pal ? gp_v  : gn_v;
    wire g_f  = pal ? gp_f  : gn_f;
    wire g_hs = pal ? gp_hs : gn_hs;
    wire g_vs = pal ? gp_vs : gn_vs;

    sync_gen #(.H_TOTAL(H_TOTAL), .H_SYNC(H_SYNC_N), .H_ACT0(H_ACT0_N),
               .V_TOTAL(V_TOTAL), .V_BLANK(V_BLANK)) u_gen_n (
        .clk     (mclk),
        .rst_b   (rst_b),
        .pix_en  (pix_en),
        .run     (run && !pal),
        .h_flag  (gn_h),
        .v_flag  (gn_v),
        .f_flag  (gn_f),
        .hsync_b (gn_hs),
        .vsync_b (gn_vs)
    );

    sync_gen #(.H_TOTAL(H_TOTAL_P), .H_SYNC(H_SYNC_P), .H_ACT0(H_ACT0_P),
               .V_TOTAL(V_TOTAL_P), .V_BLANK(V_BLANK)) u_gen_p (
        .clk     (mclk),
        .rst_b   (rst_b),
        .pix_en  (pix_en),
        .run     (run && pal),
        .h_flag  (gp_h),
        .v_flag  (gp_v),
        .f_flag  (gp_f),
        .hsync_b (gp_hs),
        .vsync_b (gp_vs)
    );

    // ---------------------------------------------------------------
    // embedded code detector
    // ---------------------------------------------------------------
    // relies on the four-byte code around every line
    reg [1:0] cs;
    reg       code_h, code_v, code_f;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cs     <= CS_IDLE;
            code_h <= 1'b0;
            code_v <= 1'b0;
            code_f <= 1'b0;
        end else if (pix_en) begin
            case (cs)
                CS_IDLE: cs <= (pix_s == `CODE_PREAMBLE_FF) ? CS_FF : CS_IDLE;
                CS_FF:   cs <= (pix_s == `CODE_PREAMBLE_00) ? CS_Z1 : CS_IDLE;
                CS_Z1:   cs <= (pix_s == `CODE_PREAMBLE_00) ? CS_Z2 : CS_IDLE;
                CS_Z2: begin
                    cs     <= CS_IDLE;
                    code_f <= pix_s[6];
                    code_v <= pix_s[5];
                    code_h <= pix_s[4];
                end
                default: cs <= CS_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // separate-sync slave decoding
    // ---------------------------------------------------------------
    reg  hs_d, vs_d;
    reg  [10:0] line_cnt;
    reg  sl_field;
    wire hs_fall = hs_d && !hs_s;
    wire vs_fall = vs_d && !vs_s;
    wire vs_chg  = vs_d != vs_s;
    reg  new_frame;
    reg  next_field;

    // sync pins are high when unused in embedded mode
    always @* begin
        new_frame  = 1'b0;
        next_field = sl_field;
        case (tmode)
            M1_SLAVE: begin
                new_frame  = vs_chg && !hs_s;
                next_field = vs_s;
            end
            M2_SLAVE: begin
                if (vs_fall && hs_fall) begin
                    new_frame  = 1'b1;
                    next_field = 1'b1;
                end else if (vs_fall && hs_s) begin
                    new_frame  = 1'b1;
                    next_field = 1'b0;
                end
            end
            M3_SLAVE: begin
                new_frame  = vs_chg && hs_s;
                next_field = vs_s;
            end
            default: begin
                new_frame  = 1'b0;
                next_field = sl_field;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hs_d     <= 1'b1;
            vs_d     <= 1'b1;
            sl_field <= 1'b0;
            line_cnt <= 11'h000;
        end else begin
            hs_d     <= hs_s;
            vs_d     <= vs_s;
            sl_field <= next_field;
            if (new_frame)
                line_cnt <= 11'h000;
            else if (hs_fall && line_cnt != 11'h7ff)
                line_cnt <= line_cnt + 11'h001;
        end
    end

    // ---------------------------------------------------------------
    // selected flags and blanking
    // ---------------------------------------------------------------
    reg cur_h, cur_v, cur_f, blank_now;

    always @* begin
        cur_h = 1'b0;
        cur_v = 1'b0;
        cur_f = 1'b0;
        if (master) begin
            cur_h = g_h;
            cur_v = g_v;
            cur_f = g_f;
        end else if (tmode == M0_SLAVE) begin
            cur_h = code_h;
            cur_v = code_v;
            cur_f = code_f;
        end else begin
            cur_h = !hs_s;
            cur_v = line_cnt < V_BLANK;
            cur_f = sl_field;
        end
        // external blank only in separate-sync slave modes
        if (!master && tmode != M0_SLAVE && !blank_input_disable)
            blank_now = !bl_s;
        else
            blank_now = cur_h || cur_v;
    end

    // ---------------------------------------------------------------
    // pixel path and start-up outputs
    // ---------------------------------------------------------------
    reg chroma_phase;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pixel_out    <= `BLACK_CHROMA;
            chroma_phase <= 1'b1;
            blank_active <= 1'b1;
            field_odd    <= 1'b0;
            frame_start  <= 1'b0;
            dac_enable   <= `DAC_RESET;
            status       <= 32'h0000_0000;
        end else begin
            dac_enable   <= mode_reg[`MODE_DAC_LSB +: 6];
            field_odd    <= cur_f;
            blank_active <= blank_now;
            // embedded and master modes mark a frame by a change of the field flag
            frame_start  <= (master || tmode == M0_SLAVE) ? (cur_f != field_odd) : new_frame;
            status       <= {24'h00_0000, cur_f, cur_v, cur_h, blank_now,
                             std_pin_s, 1'b0, video_standard};
            if (pix_en) begin
                chroma_phase <= !chroma_phase;
                // pixel taken the edge after synchronised timing edge
                if (pixel_valid_enable)
                    pixel_out <= pix_s;
                else
                    pixel_out <= chroma_phase ? `BLACK_CHROMA : `BLACK_LUMA;
            end
        end
    end

    // ---------------------------------------------------------------
    // bidirectional timing pins
    // ---------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hsync_b_out <= 1'b1;
            vsync_b_out <= 1'b1;
            blank_b_out <= 1'b1;
            hsync_b_oe  <= 1'b0;
            vsync_b_oe  <= 1'b0;
            blank_b_oe  <= 1'b0;
        end else begin
            // suppressed until pixel valid, driven only in master modes
            hsync_b_oe <= run;
            vsync_b_oe <= run;
            blank_b_oe <= run;
            case (tmode)
                M0_MASTER: begin
                    hsync_b_out <= g_h;
                    blank_b_out <= g_v;
                    vsync_b_out <= g_f;
                end
                M1_MASTER, M3_MASTER: begin
                    hsync_b_out <= g_hs;
                    vsync_b_out <= g_f;
                    blank_b_out <= !(g_h || g_v);
                end
                M2_MASTER: begin
                    hsync_b_out <= g_hs;
                    vsync_b_out <= g_vs;
                    blank_b_out <= !(g_h || g_v);
                end
                default: begin
                    hsync_b_out <= 1'b1;
                    vsync_b_out <= 1'b1;
                    blank_b_out <= 1'b1;
                end
            endcase
        end
    end
endmodule

// File: tb/video_source.sv
// Purpose: pixel and sync source on the far side of the pixel port
// Assumes: pixel rate is mclk divided by DIV, as in the front end
// Notes:   free running line and field counts
module video_source #(
    parameter int DIV  = 5,
    parameter int LINE = 32,
    parameter int LPF  = 16
) (
    input  logic       mclk,
    input  logic       rst_b,
    input  logic       sep,
    output logic [7:0] pix,
    output logic       hs_b,
    output logic       vs_b,
    output logic       bl_b,
    output logic       odd
);
    int         n, px, ln, k;
    logic       fld;
    logic [7:0] xy;
    // ---------------------------------------------------------------
    // line and field sequence
    // ---------------------------------------------------------------
    always @(posedge mclk or negedge rst_b)
        if (!rst_b)
            n <= 0;
        else
            n <= (n == 2 * DIV * LINE * LPF - 1) ? 0 : n + 1;
    always_comb begin
        px = (n / DIV) % LINE;
        ln = (n / (DIV * LINE)) % LPF;
        fld = (n >= DIV * LINE * LPF);
        k = (px < 4) ? px : px - (LINE - 4);
        xy = {1'b1, fld, ln < 2, px < 4, 4'h0};
        // end code opens each line, start code closes it
        pix = (px < 4 || px >= LINE - 4) ? (k == 0 ? 8'hff : k == 3 ? xy : 8'h00) : 8'h5a;
        // unused pins held high in embedded mode
        hs_b = !sep || px >= 4;
        // odd: both fall together; even: vsync falls mid-line
        vs_b = !sep || (fld ? !((ln == 0 && px >= LINE / 2) || ln == 1 ||
                                (ln == 2 && px < LINE / 2)) : ln >= 2);
        // high in embedded mode external blank at line end otherwise
        bl_b = !sep || px < LINE - 4;
        odd = !fld;
    end
endmodule

// File: tb/video_timing_front_sva.sv
// Purpose: port assertions for the video timing front end
// Assumes: one clock, reset active low
// Notes:   bound into every instance
module video_timing_front_sva (
    input logic       mclk,
    input logic       rst_b,
    input logic       wb_cyc_i,
    input logic       wb_stb_i,
    input logic       wb_ack_o,
    input logic       hsync_b_oe,
    input logic       vsync_b_oe,
    input logic       blank_b_oe,
    input logic [7:0] pixel_out,
    input logic       frame_start,
    input logic [5:0] dac_enable
);
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_dac_start: assert property ($rose(rst_b) |-> dac_enable == 6'h38)
        else $error("converters wrong after reset");
    chk_black_start: assert property ($rose(rst_b) |-> pixel_out == 8'h80 && !hsync_b_oe)
        else $error("start-up output wrong");
    chk_dac_cause: assert property ($changed(dac_enable) |-> wb_ack_o || $past(wb_ack_o))
        else $error("converters changed unasked");
    chk_oe_pair: assert property (hsync_b_oe == vsync_b_oe)
        else $error("sync enables differ");
    chk_blank_oe: assert property (blank_b_oe |-> hsync_b_oe)
        else $error("blank driven alone");
    chk_oe_cause: assert property ($rose(hsync_b_oe) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("drive began without write");
    chk_frame_pulse: assert property (frame_start |=> !frame_start)
        else $error("frame pulse too long");
    cover property (frame_start);
    cover property ($rose(hsync_b_oe));
    cover property (wb_ack_o && $past(wb_cyc_i));
endmodule
bind video_timing_front video_timing_front_sva i_chk (.mclk(mclk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .hsync_b_oe(hsync_b_oe),
    .vsync_b_oe(vsync_b_oe), .blank_b_oe(blank_b_oe), .pixel_out(pixel_out),
    .frame_start(frame_start), .dac_enable(dac_enable));

// File: tb/video_timing_front_tb.sv
// Purpose: self-checking bench for the video timing front end
// Assumes: source model on the pixel and sync pins
// Notes:   line and field counts shrunk for run time
module video_timing_front_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, pin = 1'b1;
    logic        sep = 1'b0, ack, hs_out, hs_oe, vs_out, vs_oe, bl_out, bl_oe, blank_active;
    logic        field_odd, frame_start, src_hs, src_vs, src_bl, src_odd;
    logic [7:0]  adr = 8'h00, src_pix, pixel_out;
    logic [31:0] wdat = 32'h0000_0000, q, rdat;
    logic [1:0]  video_standard;
    logic [5:0]  dac_enable;
    logic [3:0]  sel = 4'hf;
    wire         hs_pin = hs_oe ? hs_out : src_hs;
    wire         vs_pin = vs_oe ? vs_out : src_vs;
    wire         bl_pin = bl_oe ? bl_out : src_bl;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    video_timing_front #(.H_TOTAL(32), .V_TOTAL(16), .H_TOTAL_P(32), .V_TOTAL_P(16),
        .V_BLANK(4)) i_dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .standard_select_pin(pin), .pixel_in(src_pix), .hsync_b_in(hs_pin),
        .hsync_b_out(hs_out), .hsync_b_oe(hs_oe), .vsync_b_in(vs_pin), .vsync_b_out(vs_out),
        .vsync_b_oe(vs_oe), .blank_b_in(bl_pin), .blank_b_out(bl_out), .blank_b_oe(bl_oe),
        .pixel_out(pixel_out), .blank_active(blank_active), .field_odd(field_odd),
        .frame_start(frame_start), .video_standard(video_standard), .dac_enable(dac_enable));
    video_source i_src (.mclk(mclk), .rst_b(rst_b),
        .sep(sep), .pix(src_pix), .hs_b(src_hs), .vs_b(src_vs), .bl_b(src_bl), .odd(src_odd));
    always #4 mclk = ~mclk;
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout;
        n_mismatch++;
        $display("BAD %0t wait ran out", $time);
        summarize();
    endtask
    // hold the request until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i >= 20)
            timeout();
    endtask
    task automatic wait_sig(input int s);
        int i;
        for (i = 0; i < 6000; i++) begin
            @(posedge mclk);
            if ((s == 0 && frame_start === 1'b1) || (s == 1 && pixel_out === 8'h5a) ||
                (s == 2 && hs_out === 1'b0) || (s == 3 && hs_out === 1'b1) ||
                (s == 4 && blank_active === 1'b1 && src_hs === 1'b1 && src_bl === 1'b1))
                break;
        end
        if (i >= 6000)
            timeout();
        samples_checked++;
    endtask
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        int m;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(32'(dac_enable), 32'h0000_0038);
        chk(32'({hs_oe, vs_oe, bl_oe}), 32'h0000_0000);
        chk(32'(pixel_out == 8'h80 || pixel_out == 8'h10), 32'h0000_0001);
        chk(32'(video_standard), 32'h0000_0001);
        wb(1'b0, 8'h00, 32'h0000_0000);
        chk(q, 32'h0000_3800);
        wb(1'b0, 8'h04, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        // lane 0 off: the timing byte must stay as it was
        sel <= 4'he;
        wb(1'b1, 8'h04, 32'h0000_00ff);
        sel <= 4'hf;
        wb(1'b0, 8'h04, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        pin <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(32'(video_standard), 32'h0000_0000);
        wb(1'b1, 8'h00, 32'h0000_3861);
        repeat (4) @(posedge mclk);
        chk(32'(video_standard), 32'h0000_0001);
        for (m = 0; m < 8; m++) begin
            sep <= (m != 0);
            if (m == 7)
                wb(1'b1, 8'h00, 32'h0000_3860);
            wb(1'b1, 8'h04, 32'h0000_00f0 | 32'(m));
            wb(1'b0, 8'h04, 32'h0000_0000);
            chk(q, 32'h0000_00f0 | 32'(m));
            repeat (8) @(posedge mclk);
            chk(32'(hs_oe), 32'(m % 2));
            if (m % 2 == 1) begin
                wait_sig(2);
                wait_sig(3);
            end
            if (m == 0)
                wait_sig(0);
            if (m == 4) begin
                wait_sig(0);
                repeat (2) @(posedge mclk);
                chk(32'(field_odd), 32'(src_odd));
                wait_sig(0);
                repeat (2) @(posedge mclk);
                chk(32'(field_odd), 32'(src_odd));
                wait_sig(1);
                chk(32'(blank_active), 32'h0000_0000);
                wb(1'b1, 8'h04, 32'h0000_000c);
                wait_sig(4);
            end
        end
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(32'({hs_oe, dac_enable}), 32'h0000_0038);
        rst_b <= 1'b1;
        wb(1'b0, 8'h00, 32'h0000_0000);
        chk(q, 32'h0000_3800);
        summarize();
    end
endmodule
